/* File: core/ih_pkg.sv */
// constants and carrier types for the interrupt handler
package ih_pkg;

    localparam int NUM_SRC = 22;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_TIMER_CTRL = 8'h88;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'hA8;
    localparam logic [7:0] IDX_SOFT_FLAGS = 8'hAD;
    localparam logic [7:0] IDX_PRIO = 8'hB8;
    localparam logic [7:0] IDX_EXT_EN_ONE = 8'hE6;
    localparam logic [7:0] IDX_EXT_EN_TWO = 8'hE7;
    localparam logic [7:0] IDX_PRIO_ONE = 8'hF6;
    localparam logic [7:0] IDX_PRIO_TWO = 8'hF7;

    // field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int TYPE_A_BIT = 0;
    localparam int PEND_A_BIT = 1;
    localparam int TYPE_B_BIT = 2;
    localparam int PEND_B_BIT = 3;
    localparam int SOFT_LSB = 4;

    // writable bits of each register
    localparam logic [7:0] IRQ_ENABLE_MASK = 8'hBF;
    localparam logic [7:0] PRIO_MASK = 8'h3F;
    localparam logic [7:0] EXT_EN_ONE_MASK = 8'hF5;
    localparam logic [7:0] EXT_EN_TWO_MASK = 8'hBE;
    localparam logic [7:0] REG_RESET = 8'h00;

    // fixed source orders
    localparam logic [4:0] ORD_EXT_A = 5'h00;
    localparam logic [4:0] ORD_EXT_B = 5'h02;
    localparam int ORD_SOFT0 = 16;

    // vector = base + stride * order
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } ih_ahb_req_t;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } ih_ahb_rsp_t;

    typedef struct packed {
        logic instr_done;
        logic return_from_interrupt_done;
        logic irq_ack;
    } ih_core_in_t;

    typedef struct packed {
        logic irq_req;
        logic irq_high;
        logic [15:0] irq_vector;
    } ih_core_out_t;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [7:0] irq_enable_reg;
        logic [7:0] extended_enable_reg_one;
        logic [7:0] extended_enable_reg_two;
        logic [7:0] prio_reg;
        logic [7:0] prio_reg_one;
        logic [7:0] prio_reg_two;
        logic ext_line_a_type_select;
        logic ext_line_b_type_select;
        logic ext_line_a_pending;
        logic ext_line_b_pending;
        logic [3:0] soft_req;
        logic [1:0] sync_a;
        logic [1:0] sync_b;
        logic prev_a;
        logic prev_b;
        logic active_low;
        logic active_high;
        logic post_return_gate;
        logic req;
        logic req_high;
        logic [4:0] req_order;
        logic [15:0] vector;
        logic [31:0] hrdata;
    } ih_state_t;

endpackage

/* File: core/ih_interrupt_handler.sv */
// interrupt handler: pending flags, enables, priority pick, core handshake
//
// Implementation choice: the AHB-Lite slave port.
module ih_interrupt_handler
(
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire ih_pkg::ih_ahb_req_t ahb_i, // register bus request
    output ih_pkg::ih_ahb_rsp_t ahb_o, // register bus response
    input wire logic [21:0] periph_pending, // peripheral flags by order
    input wire logic ext_line_a_pin_n, // external line zero pin
    input wire logic ext_line_b_pin_n, // external line one pin
    input wire ih_pkg::ih_core_in_t core_i, // sequencer handshake
    output ih_pkg::ih_core_out_t core_o // request and vector
);
    import ih_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // spread three enable-style registers over the source orders
    // orders 7, 9, 14 and 20 have no enable and never request
    function automatic logic [21:0] by_order(input logic [7:0] base,
                                             input logic [7:0] one,
                                             input logic [7:0] two);
        by_order = {two[7], 1'b0, two[5:2], two[1], 1'b0,
                    one[7:4], 1'b0, one[2], 1'b0, one[0],
                    base[5:0]};
    endfunction

    // lowest set bit wins: {found, order}
    function automatic logic [5:0] first_set(input logic [21:0] v);
        first_set = 6'h00;
        // scan downwards so the last hit is the lowest order
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                first_set = {1'b1, 5'(i)};
            end
        end
    endfunction

    // vector = base + 8 * order
    function automatic logic [15:0] vector_of(input logic [4:0] ord);
        vector_of = VEC_BASE + {8'h00, ord, 3'h0};
    endfunction

    // a transfer starts when selected, ready and NONSEQ; IDLE, BUSY and SEQ never start one
    function automatic logic starts(input ih_ahb_req_t r);
        starts = r.hsel & r.hready & (r.htrans == HTRANS_NONSEQ);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    ih_state_t s_q;
    ih_state_t s_d;

    logic addr_ok;
    logic [7:0] addr_idx;
    logic take;
    logic [21:0] pending;
    logic [21:0] enabled;
    logic [21:0] high;
    logic [21:0] elig;
    logic [5:0] pick_hi;
    logic [5:0] pick_lo;
    logic [7:0] wdata;
    logic fall_a;
    logic fall_b;

    // zero wait states: each transfer ends in its data phase
    assign ahb_o.hreadyout = 1'b1;
    assign ahb_o.hresp = HRESP_OKAY;
    assign ahb_o.hrdata = s_q.hrdata;

    // the sequencer samples this at its instruction boundary
    assign core_o.irq_req = s_q.req & ~core_i.return_from_interrupt_done
                          & (~s_q.post_return_gate | core_i.instr_done);
    assign core_o.irq_high = s_q.req_high;
    assign core_o.irq_vector = s_q.vector;

    // an ack with no request showing is ignored
    assign take = core_i.irq_ack & core_o.irq_req;

    ////////////////////////////////////////////////////////////////////////
    // request selection

    always_comb
    begin
        pending = periph_pending;
        pending[ORD_EXT_A] = s_q.ext_line_a_pending;
        pending[ORD_EXT_B] = s_q.ext_line_b_pending;
        pending[ORD_SOFT0 +: 4] = s_q.soft_req;
        // the global bit gates all sources together
        enabled = by_order(s_q.irq_enable_reg, s_q.extended_enable_reg_one,
                           s_q.extended_enable_reg_two)
                & {NUM_SRC{s_q.irq_enable_reg[GLOBAL_EN_BIT]}};
        high = by_order(s_q.prio_reg, s_q.prio_reg_one,
                        s_q.prio_reg_two);
        elig = pending & enabled;
        // a high routine blocks all; a low routine blocks low ones
        pick_hi = first_set(elig & high) & {6{~s_q.active_high}};
        pick_lo = first_set(elig & ~high)
                & {6{~s_q.active_high & ~s_q.active_low}};
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    always_comb
    begin
        addr_idx = ahb_i.haddr[9:2];
        addr_ok = (ahb_i.haddr[31:10] == 22'h00_0000)
                & (ahb_i.haddr[1:0] == 2'h0);
        // only the low byte carries register data
        wdata = ahb_i.hwdata[7:0];
        // edges read the second flop only, never the raw pin
        fall_a = s_q.prev_a & ~s_q.sync_a[1];
        fall_b = s_q.prev_b & ~s_q.sync_b[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d = s_q;

        // pins pass two flops before use
        s_d.sync_a = {s_q.sync_a[0], ext_line_a_pin_n};
        s_d.sync_b = {s_q.sync_b[0], ext_line_b_pin_n};
        s_d.prev_a = s_q.sync_a[1];
        s_d.prev_b = s_q.sync_b[1];

        // vectoring clears edge-mode external flags only
        if (take && s_q.req_order == ORD_EXT_A && s_q.ext_line_a_type_select)
        begin
            s_d.ext_line_a_pending = 1'b0;
        end
        if (take && s_q.req_order == ORD_EXT_B && s_q.ext_line_b_type_select)
        begin
            s_d.ext_line_b_pending = 1'b0;
        end

        // data phase of a write
        if (s_q.wr_pend)
        begin
            case (s_q.wr_idx)
                IDX_IRQ_ENABLE:
                begin
                    s_d.irq_enable_reg = wdata & IRQ_ENABLE_MASK;
                end
                IDX_EXT_EN_ONE:
                begin
                    s_d.extended_enable_reg_one = wdata & EXT_EN_ONE_MASK;
                end
                IDX_EXT_EN_TWO:
                begin
                    s_d.extended_enable_reg_two = wdata & EXT_EN_TWO_MASK;
                end
                IDX_PRIO:
                begin
                    s_d.prio_reg = wdata & PRIO_MASK;
                end
                IDX_PRIO_ONE:
                begin
                    s_d.prio_reg_one = wdata & EXT_EN_ONE_MASK;
                end
                IDX_PRIO_TWO:
                begin
                    s_d.prio_reg_two = wdata & EXT_EN_TWO_MASK;
                end
                IDX_TIMER_CTRL:
                begin
                    // in level mode the pin overrides these flag writes
                    s_d.ext_line_a_type_select = wdata[TYPE_A_BIT];
                    s_d.ext_line_b_type_select = wdata[TYPE_B_BIT];
                    s_d.ext_line_a_pending = wdata[PEND_A_BIT];
                    s_d.ext_line_b_pending = wdata[PEND_B_BIT];
                end
                IDX_SOFT_FLAGS:
                begin
                    // low nibble is not stored
                    s_d.soft_req = wdata[SOFT_LSB +: 4];
                end
                default:
                begin
                    s_d.wr_pend = 1'b0;
                end
            endcase
        end

        // pin events come last so a set beats a clear in the same cycle
        if (s_q.ext_line_a_type_select)
        begin
            if (fall_a)
            begin
                s_d.ext_line_a_pending = 1'b1;
            end
        end
        else
        begin
            s_d.ext_line_a_pending = ~s_q.sync_a[1];
        end
        if (s_q.ext_line_b_type_select)
        begin
            if (fall_b)
            begin
                s_d.ext_line_b_pending = 1'b1;
            end
        end
        else
        begin
            s_d.ext_line_b_pending = ~s_q.sync_b[1];
        end

        // address phase; a bad address never arms a write
        s_d.wr_pend = 1'b0;
        if (starts(ahb_i))
        begin
            s_d.wr_pend = ahb_i.hwrite & addr_ok;
            s_d.wr_idx = addr_idx;
        end

        // in-service levels
        // the return cycle masks the request, so no take meets a pop
        if (core_i.return_from_interrupt_done)
        begin
            if (s_q.active_high)
            begin
                s_d.active_high = 1'b0;
            end
            else
            begin
                s_d.active_low = 1'b0;
            end
            s_d.post_return_gate = 1'b1;
        end
        else if (core_i.instr_done)
        begin
            s_d.post_return_gate = 1'b0;
        end
        if (take)
        begin
            if (s_q.req_high)
            begin
                s_d.active_high = 1'b1;
            end
            else
            begin
                s_d.active_low = 1'b1;
            end
        end

        // one cycle of detect: picks are registered every clock
        if (pick_hi[5])
        begin
            s_d.req = ~take;
            s_d.req_high = 1'b1;
            s_d.req_order = pick_hi[4:0];
        end
        else if (pick_lo[5])
        begin
            s_d.req = ~take;
            s_d.req_high = 1'b0;
            s_d.req_order = pick_lo[4:0];
        end
        else
        begin
            s_d.req = 1'b0;
        end
        // vector follows the order always; it matters only with a request
        s_d.vector = vector_of(s_d.req_order);

        // read data from the next state so a write just before is seen
        if (starts(ahb_i) && !ahb_i.hwrite)
        begin
            s_d.hrdata = 32'h0000_0000;
            if (addr_ok)
            begin
                case (addr_idx)
                    IDX_IRQ_ENABLE:
                    begin
                        s_d.hrdata[7:0] = s_d.irq_enable_reg;
                    end
                    IDX_EXT_EN_ONE:
                    begin
                        s_d.hrdata[7:0] = s_d.extended_enable_reg_one;
                    end
                    IDX_EXT_EN_TWO:
                    begin
                        s_d.hrdata[7:0] = s_d.extended_enable_reg_two;
                    end
                    IDX_PRIO:
                    begin
                        s_d.hrdata[7:0] = s_d.prio_reg;
                    end
                    IDX_PRIO_ONE:
                    begin
                        s_d.hrdata[7:0] = s_d.prio_reg_one;
                    end
                    IDX_PRIO_TWO:
                    begin
                        s_d.hrdata[7:0] = s_d.prio_reg_two;
                    end
                    IDX_TIMER_CTRL:
                    begin
                        s_d.hrdata[3:0] = {s_d.ext_line_b_pending,
                                           s_d.ext_line_b_type_select,
                                           s_d.ext_line_a_pending,
                                           s_d.ext_line_a_type_select};
                    end
                    IDX_SOFT_FLAGS:
                    begin
                        s_d.hrdata[7:0] = {s_d.soft_req, 4'h0};
                    end
                    default:
                    begin
                        s_d.hrdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // all zero: vector shows the reset vector, enables off
            s_q <= '0;
            // synchronisers start at the idle high level, so level mode
            // shows no false flag while the pipeline fills
            s_q.sync_a <= 2'b11;
            s_q.sync_b <= 2'b11;
            s_q.prev_a <= 1'b1;
            s_q.prev_b <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule // ih_interrupt_handler

/* File: tb/ih_interrupt_handler_monitor.sv */
// port checker for the interrupt handler, bound to its top module
module ih_interrupt_handler_monitor
(
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire ih_pkg::ih_ahb_req_t ahb_i, // bus request
    input wire ih_pkg::ih_ahb_rsp_t ahb_o, // bus response
    input wire logic [21:0] periph_pending, // peripheral flags
    input wire logic ext_line_a_pin_n, // line zero pin
    input wire logic ext_line_b_pin_n, // line one pin
    input wire ih_pkg::ih_core_in_t core_i, // core strobes
    input wire ih_pkg::ih_core_out_t core_o // request out
);
    timeunit 1ns;
    timeprecision 1ps;
    import ih_pkg::*;
    logic ph_q;
    logic wr_q;
    logic [7:0] idx_q;
    logic [7:0] en_q;
    logic [7:0] tc_q;
    logic hi_q;
    logic take;
    logic rd_sw;
    logic rd_tc;
    assign take = core_i.irq_ack && core_o.irq_req;
    assign rd_sw = ph_q && !wr_q && idx_q == IDX_SOFT_FLAGS;
    assign rd_tc = ph_q && !wr_q && idx_q == IDX_TIMER_CTRL;
    ////////////////////////////////////////////////////////////
    // shadows built from bus writes and the core handshake; the design keeps its own
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_q <= 1'b0;
            wr_q <= 1'b0;
            idx_q <= 8'h00;
            en_q <= 8'h00;
            tc_q <= 8'h00;
            hi_q <= 1'b0;
        end
        else
        begin
            ph_q <= ahb_i.hsel && ahb_i.hready &&
                ahb_i.htrans == HTRANS_NONSEQ && ahb_i.haddr[31:10] == 22'h0;
            wr_q <= ahb_i.hwrite;
            idx_q <= ahb_i.haddr[9:2];
            if (ph_q && wr_q && idx_q == IDX_IRQ_ENABLE)
                en_q <= ahb_i.hwdata[7:0];
            if (ph_q && wr_q && idx_q == IDX_TIMER_CTRL)
                tc_q <= ahb_i.hwdata[7:0];
            if (take && core_o.irq_high)
                hi_q <= 1'b1;
            else if (core_i.return_from_interrupt_done)
                hi_q <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // the request register lags an enable write by one cycle
    property p_global;
        core_o.irq_req |-> en_q[GLOBAL_EN_BIT] || $past(en_q[GLOBAL_EN_BIT]);
    endproperty
    a_global: assert property (p_global)
        else $error("request with global enable off");
    property p_ext_a;
        core_o.irq_req && core_o.irq_vector == 16'h0003 |-> en_q[0] ||
            $past(en_q[0]);
    endproperty
    a_ext_a: assert property (p_ext_a)
        else $error("line zero vector while disabled");
    property p_ext_b;
        core_o.irq_req && core_o.irq_vector == 16'h0013 |-> en_q[2] ||
            $past(en_q[2]);
    endproperty
    a_ext_b: assert property (p_ext_b)
        else $error("line one vector while disabled");
    property p_vec;
        core_o.irq_req |-> core_o.irq_vector[2:0] == 3'h3 &&
            core_o.irq_vector <= 16'h00AB && !(core_o.irq_vector inside
            {16'h003B, 16'h004B, 16'h0073, 16'h00A3});
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector outside the fixed table");
    property p_take;
        take |=> !core_o.irq_req;
    endproperty
    a_take: assert property (p_take)
        else $error("request stays after take");
    property p_high;
        hi_q |-> !core_o.irq_req;
    endproperty
    a_high: assert property (p_high)
        else $error("high routine preempted");
    property p_return_from_interrupt;
        core_i.return_from_interrupt_done |-> !core_o.irq_req ##1
            (!core_o.irq_req || core_i.instr_done);
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt)
        else $error("request before the next instruction");
    property p_soft_low;
        rd_sw |-> ahb_o.hrdata[3:0] == 4'h0 && ahb_o.hrdata[31:8] == 24'h0;
    endproperty
    a_soft_low: assert property (p_soft_low)
        else $error("soft flag low bits not zero");
    property p_level_b;
        (!ext_line_b_pin_n)[*7] ##0 (rd_tc && !tc_q[TYPE_B_BIT]) |->
            ahb_o.hrdata[PEND_B_BIT];
    endproperty
    a_level_b: assert property (p_level_b)
        else $error("level flag does not follow pin");
endmodule // ih_interrupt_handler_monitor

bind ih_interrupt_handler ih_interrupt_handler_monitor u_mon
(
    .hclk(hclk),
    .hresetn(hresetn),
    .ahb_i(ahb_i),
    .ahb_o(ahb_o),
    .periph_pending(periph_pending),
    .ext_line_a_pin_n(ext_line_a_pin_n),
    .ext_line_b_pin_n(ext_line_b_pin_n),
    .core_i(core_i),
    .core_o(core_o)
);

/* File: tb/ih_core_model.sv */
// instruction sequencer model: varying instruction lengths, ack, return
module ih_core_model
(
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire ih_pkg::ih_core_out_t core_o, // handler request
    output ih_pkg::ih_core_in_t core_i, // sequencer strobes
    output logic taken, // a request was taken
    output logic [15:0] taken_vec // vector of that take
);
    timeunit 1ns;
    timeprecision 1ps;
    import ih_pkg::*;
    logic [1:0] cyc_q;
    logic [1:0] len_q;
    int depth_q;
    int svc_q;
    logic take;
    assign take = core_i.irq_ack && core_o.irq_req;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            core_i <= '0;
            cyc_q <= 2'd0;
            len_q <= 2'd0;
            depth_q <= 0;
            svc_q <= 0;
            taken <= 1'b0;
            taken_vec <= 16'h0000;
        end
        else
        begin
            taken <= take;
            taken_vec <= core_o.irq_vector;
            // routine runs eight instructions, outer one four more
            if (take)
            begin
                depth_q <= depth_q + 1;
                svc_q <= 8;
            end
            else if (core_i.return_from_interrupt_done)
            begin
                depth_q <= depth_q - 1;
                svc_q <= 4;
            end
            else if (core_i.instr_done && svc_q > 0)
                svc_q <= svc_q - 1;
            if (cyc_q == len_q)
            begin
                cyc_q <= 2'd0;
                len_q <= (len_q == 2'd2) ? 2'd0 : len_q + 2'd1;
                core_i.instr_done <= 1'b1;
                core_i.irq_ack <= 1'b1;
                core_i.return_from_interrupt_done <= depth_q > 0 && svc_q == 0 && !take &&
                    !core_i.return_from_interrupt_done;
            end
            else
            begin
                cyc_q <= cyc_q + 2'd1;
                core_i <= '0;
            end
        end
    end
endmodule // ih_core_model

/* File: tb/ih_testbench.sv */
// self-checking bench for the interrupt handler
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ih_pkg::*;
    localparam logic [31:0] A_TC = {22'h0, IDX_TIMER_CTRL, 2'b00};
    localparam logic [31:0] A_IE = {22'h0, IDX_IRQ_ENABLE, 2'b00};
    localparam logic [31:0] A_SW = {22'h0, IDX_SOFT_FLAGS, 2'b00};
    localparam logic [31:0] A_IP = {22'h0, IDX_PRIO, 2'b00};
    localparam logic [31:0] A_E1 = {22'h0, IDX_EXT_EN_ONE, 2'b00};
    localparam logic [31:0] A_E2 = {22'h0, IDX_EXT_EN_TWO, 2'b00};
    logic hclk;
    logic hresetn;
    ih_ahb_req_t req;
    ih_ahb_req_t ahb_i;
    ih_ahb_rsp_t ahb_o;
    logic [21:0] pend;
    logic pin_a;
    logic pin_b;
    ih_core_in_t core_i;
    ih_core_out_t core_o;
    logic taken;
    logic [15:0] taken_vec;
    logic [15:0] exp_q[$];
    logic [31:0] v;
    integer seed;
    int n_mismatch;
    int cmp_count;
    int cyc;
    int ords[12] = '{1, 3, 4, 5, 6, 8, 10, 11, 12, 13, 15, 21};
    logic [31:0] regs[6] = '{A_TC, A_IE, A_SW, A_IP, A_E1, A_E2};
    always #12.5 hclk = ~hclk;
    always_comb
    begin
        ahb_i = req;
        ahb_i.hready = ahb_o.hreadyout;
    end
    ih_interrupt_handler DUT (.hclk(hclk), .hresetn(hresetn),
        .ahb_i(ahb_i), .ahb_o(ahb_o), .periph_pending(pend),
        .ext_line_a_pin_n(pin_a), .ext_line_b_pin_n(pin_b),
        .core_i(core_i), .core_o(core_o));
    ih_core_model u_core (.hclk(hclk), .hresetn(hresetn),
        .core_o(core_o), .core_i(core_i), .taken(taken),
        .taken_vec(taken_vec));
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // master holds each phase until hready is sampled high
    task automatic bus(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] r);
        req.hsel <= 1'b1;
        req.htrans <= HTRANS_NONSEQ;
        req.haddr <= a;
        req.hwrite <= w;
        req.hsize <= 3'h2;
        @(posedge hclk);
        while (ahb_o.hreadyout !== 1'b1)
            @(posedge hclk);
        req.hsel <= 1'b0;
        req.htrans <= 2'h0;
        req.hwdata <= d;
        @(posedge hclk);
        while (ahb_o.hreadyout !== 1'b1)
            @(posedge hclk);
        r = ahb_o.hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        check("hrdata", r, e);
    endtask
    task automatic exp_ord(input int o);
        exp_q.push_back(VEC_BASE + 16'(8 * o));
    endtask
    task automatic wait_q(input int n);
        int k;
        k = 0;
        while (exp_q.size() > n && k < 500)
        begin
            @(posedge hclk);
            k++;
        end
        check("take count", 32'(exp_q.size()), 32'(n));
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    always @(posedge hclk)
        if (taken === 1'b1)
            check("vector", {16'h0, taken_vec}, {16'h0, exp_q.size() > 0 ?
                exp_q.pop_front() : 16'hFFFF});
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        req = '0;
        pend = '0;
        pin_a = 1'b1;
        pin_b = 1'b1;
        seed = 32'h48a0_c4a0;
        idle(2);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (regs[i])
            rd(regs[i], 32'h0000_0000);
        rd(32'h0000_0004, 32'h0000_0000);
        repeat (3)
        begin
            v = $random(seed);
            wr(A_E1, v);
            rd(A_E1, v & {24'h0, EXT_EN_ONE_MASK});
        end
        wr(A_E1, 32'h0000_0000);
        // flags set while disabled must stay silent
        wr(A_SW, 32'h0000_00FF);
        rd(A_SW, 32'h0000_00F0);
        idle(20);
        wr(A_SW, 32'h0000_0000);
        wr(A_IE, 32'h0000_0002);
        pend[1] <= 1'b1;
        idle(20);
        exp_ord(1);
        wr(A_IE, 32'h0000_0082);
        wait_q(0);
        pend[1] <= 1'b0;
        idle(20);
        wr(A_IE, {24'h0, IRQ_ENABLE_MASK});
        wr(A_E1, {24'h0, EXT_EN_ONE_MASK});
        wr(A_E2, {24'h0, EXT_EN_TWO_MASK});
        foreach (ords[i])
        begin
            pend[ords[i]] <= 1'b1;
            exp_ord(ords[i]);
            wait_q(0);
            pend[ords[i]] <= 1'b0;
            idle(20);
        end
        pend[4] <= 1'b1;
        pend[1] <= 1'b1;
        exp_ord(1);
        exp_ord(4);
        wait_q(1);
        pend[1] <= 1'b0;
        wait_q(0);
        pend[4] <= 1'b0;
        idle(20);
        // flag left set across the return re-enters
        pend[5] <= 1'b1;
        exp_ord(5);
        exp_ord(5);
        wait_q(0);
        pend[5] <= 1'b0;
        idle(20);
        wr(A_IP, 32'h0000_0008);
        pend[1] <= 1'b1;
        exp_ord(1);
        wait_q(0);
        pend[1] <= 1'b0;
        pend[3] <= 1'b1;
        exp_ord(3);
        wait_q(0);
        pend[3] <= 1'b0;
        idle(30);
        wr(A_IP, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            wr(A_SW, 32'h0000_0010 << i);
            exp_ord(ORD_SOFT0 + i);
            wait_q(0);
            wr(A_SW, 32'h0000_0000);
            idle(20);
        end
        wr(A_TC, 32'h0000_0001);
        pin_a <= 1'b0;
        exp_ord(0);
        wait_q(0);
        idle(4);
        rd(A_TC, 32'h0000_0001);
        pin_a <= 1'b1;
        wr(A_IE, 32'h0000_0080);
        pin_b <= 1'b0;
        idle(6);
        rd(A_TC, 32'h0000_0009);
        pin_b <= 1'b1;
        idle(6);
        rd(A_TC, 32'h0000_0001);
        wr(A_IE, 32'h0000_0084);
        pin_b <= 1'b0;
        exp_ord(2);
        wait_q(0);
        pin_b <= 1'b1;
        idle(30);
        print_verdict();
    end
endmodule // testbench
